/* File: core/rtcsw_cfg.svh */
// Offsets, field positions, reset values and timing counts of the slow-clock block.
`ifndef RTCSW_CFG_SVH
`define RTCSW_CFG_SVH

`define RTCSW_ADR_W 8
`define RTCSW_OFF_SECONDS 8'h00
`define RTCSW_OFF_STATUS 8'h04
`define RTCSW_OFF_MASK 8'h08
`define RTCSW_OFF_STATE 8'h0C
`define RTCSW_OFF_PMCTL 8'h98

`define RTCSW_PMCTL_DB_EN_BIT 0
`define RTCSW_PMCTL_RESET 32'h0000_0000
`define RTCSW_MASK_RESET 3'h0
`define RTCSW_SECONDS_RESET 32'h0000_0000

`define RTCSW_EVT_WAKE_BIT 0
`define RTCSW_EVT_SEC_BIT 1
`define RTCSW_EVT_GATE_BIT 2
`define RTCSW_STATE_GATED_BIT 0
`define RTCSW_STATE_WAKE_BIT 1

`define RTCSW_MCLK_HZ 125000000
`define RTCSW_SLOW_HZ 32768
`define RTCSW_SEC_DIV 32768
`define RTCSW_DB_SAMPLES 3

`endif

/* File: core/rtcsw_pkg.sv */
// Types shared by the slow-clock block.
`default_nettype none
package rtcsw_pkg;

  typedef struct packed {
    logic gate;
    logic sec;
    logic wake;
  } rtcsw_evt_t;

  typedef enum logic [2:0] {
    RTCSW_DB_LOW = 3'b001,
    RTCSW_DB_RISE = 3'b010,
    RTCSW_DB_HIGH = 3'b100
  } rtcsw_db_state_t;

endpackage
`default_nettype wire

/* File: core/rtcsw_top.sv */
// Slow-clock time keeping, wake de-bounce and Wishbone register file.
//
// Local design decision: the Wishbone interface to the registers.
`default_nettype none
`include "rtcsw_cfg.svh"

module rtcsw_top
  import rtcsw_pkg::*;
#(
  parameter int MCLK_HZ = `RTCSW_MCLK_HZ,
  parameter int SLOW_HZ = `RTCSW_SLOW_HZ,
  parameter int SEC_DIV = `RTCSW_SEC_DIV,
  parameter int DB_SAMPLES = `RTCSW_DB_SAMPLES
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`RTCSW_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic core_supply_ok,
  input wire logic power_on_reset_input_n,
  input wire logic external_wake_input,
  output logic slow_clock_gated,
  output logic wake_detected,
  output logic [31:0] seconds_count,
  output logic irq
);

  // Accumulator width follows from the master clock rate, prescaler and filter widths from the counts.
  localparam int ACC_W = $clog2(MCLK_HZ) + 1;
  localparam int PRE_W = $clog2(SEC_DIV);
  localparam int DBC_W = $clog2(DB_SAMPLES + 1);

  // Constants are sized to the registers that they meet.
  localparam logic [ACC_W-1:0] ACC_MOD = ACC_W'(MCLK_HZ);
  localparam logic [ACC_W-1:0] ACC_INC = ACC_W'(SLOW_HZ);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(SEC_DIV - 1);
  localparam logic [DBC_W-1:0] DBC_LAST = DBC_W'(DB_SAMPLES - 1);

  // Word decode: the two low address bits select no register.
  function automatic logic reg_hit(
    input logic [`RTCSW_ADR_W-1:0] adr,
    input logic [`RTCSW_ADR_W-1:0] off
  );
    reg_hit = (adr[`RTCSW_ADR_W-1:2] == off[`RTCSW_ADR_W-1:2]);
  endfunction

  // Byte-lane merge of write data into an old word.
  function automatic logic [31:0] sel_merge(
    input logic [31:0] old,
    input logic [31:0] wdat,
    input logic [3:0] sel
  );
    sel_merge = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        sel_merge[8*i +: 8] = wdat[8*i +: 8];
      end
    end
  endfunction

  // Gate state and slow tick generation.
  logic gated_r;
  logic gated_q_r;
  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] acc_nxt;

  // Time keeping.
  logic [PRE_W-1:0] pre_r;
  logic [31:0] sec_r;
  logic [31:0] sec_nxt;

  // Wake input and de-bounce filter.
  logic wake_in_r;
  logic wake_lvl_q_r;
  rtcsw_db_state_t db_state_r;
  rtcsw_db_state_t db_state_nxt;
  logic [DBC_W-1:0] db_cnt_r;
  logic [DBC_W-1:0] db_cnt_nxt;

  // Software visible registers.
  logic [31:0] pmctl_r;
  logic [2:0] status_r;
  logic [2:0] status_nxt;
  logic [2:0] mask_r;

  // Bus answer.
  logic ack_r;
  logic [31:0] dat_r;

  // Gating cause and slow tick.
  wire gate_cond = ~core_supply_ok | ~power_on_reset_input_n;
  wire [ACC_W-1:0] acc_sum = acc_r + ACC_INC;
  wire acc_wrap = (acc_sum >= ACC_MOD);
  wire slow_tick = acc_wrap & ~gated_r;
  wire sec_tick = slow_tick & (pre_r == PRE_LAST);

  // Wake level seen by the rise detector, filtered or bypassed.
  wire db_en = pmctl_r[`RTCSW_PMCTL_DB_EN_BIT];
  wire db_out = (db_state_r == RTCSW_DB_HIGH);
  wire wake_lvl = db_en ? db_out : wake_in_r;
  rtcsw_evt_t evt;

  // Register decode; a request is taken only while no ack stands.
  wire req = wb_cyc_i & wb_stb_i & ~ack_r;
  wire wr = req & wb_we_i;
  wire rd = req & ~wb_we_i;
  wire hit_sec = reg_hit(wb_adr_i, `RTCSW_OFF_SECONDS);
  wire hit_stat = reg_hit(wb_adr_i, `RTCSW_OFF_STATUS);
  wire hit_mask = reg_hit(wb_adr_i, `RTCSW_OFF_MASK);
  wire hit_state = reg_hit(wb_adr_i, `RTCSW_OFF_STATE);
  wire hit_pm = reg_hit(wb_adr_i, `RTCSW_OFF_PMCTL);
  wire sec_wr = wr & hit_sec;
  wire mask_wr = wr & hit_mask;
  wire pm_wr = wr & hit_pm;
  wire [31:0] wmask = sel_merge(32'h0000_0000, 32'hFFFF_FFFF, wb_sel_i);
  wire [2:0] status_clr = (wr & hit_stat) ? (wb_dat_i[2:0] & wmask[2:0]) : 3'h0;
  wire [31:0] state_word = {30'h0, wake_lvl, gated_r};
  wire [31:0] rd_mux = hit_sec ? sec_r :
                       hit_stat ? {29'h0, status_r} :
                       hit_mask ? {29'h0, mask_r} :
                       hit_state ? state_word :
                       hit_pm ? pmctl_r : 32'h0000_0000;

  // Event sources; a set in the same cycle as a clear wins.
  assign evt.wake = wake_lvl & ~wake_lvl_q_r;
  assign evt.sec = sec_tick;
  assign evt.gate = gated_r & ~gated_q_r;
  assign status_nxt = (status_r & ~status_clr) | evt;

  // The slow clock is modelled as a tick from a phase accumulator; gating suppresses the tick.
  assign acc_nxt = acc_wrap ? acc_sum - ACC_MOD : acc_sum;

  // A software load of the seconds counter wins over a tick in the same cycle.
  assign sec_nxt = sec_wr ? sel_merge(sec_r, wb_dat_i, wb_sel_i) :
                   sec_tick ? sec_r + 32'h0000_0001 : sec_r;

  // The filter only advances on slow ticks, so a wake pulse seen while gated never passes it.
  // A level must be seen high on a run of slow ticks before the filter output rises.
  // Any low sample on a tick sends the filter back to idle.
  always_comb begin
    db_state_nxt = db_state_r;
    db_cnt_nxt = db_cnt_r;
    if (slow_tick) begin
      unique case (db_state_r)
        // Idle: the first high sample starts the count.
        RTCSW_DB_LOW: begin
          db_cnt_nxt = '0;
          if (wake_in_r) begin
            db_state_nxt = (DB_SAMPLES <= 1) ? RTCSW_DB_HIGH : RTCSW_DB_RISE;
            db_cnt_nxt = DBC_W'(1);
          end
        end
        // Counting: the last of the required samples raises the output.
        RTCSW_DB_RISE: begin
          if (!wake_in_r) begin
            db_state_nxt = RTCSW_DB_LOW;
            db_cnt_nxt = '0;
          end else if (db_cnt_r == DBC_LAST) begin
            db_state_nxt = RTCSW_DB_HIGH;
          end else begin
            db_cnt_nxt = db_cnt_r + DBC_W'(1);
          end
        end
        // High: the output stands until a low sample.
        RTCSW_DB_HIGH: begin
          if (!wake_in_r) begin
            db_state_nxt = RTCSW_DB_LOW;
            db_cnt_nxt = '0;
          end
        end
        default: begin
          db_state_nxt = RTCSW_DB_LOW;
          db_cnt_nxt = '0;
        end
      endcase
    end
  end

  // The gate state is the registered cause; its delayed copy finds the entry edge.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      gated_r <= 1'b0;
      gated_q_r <= 1'b0;
    end else begin
      gated_r <= gate_cond;
      gated_q_r <= gated_r;
    end
  end

  // The accumulator runs on through gating; only its tick is suppressed.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      acc_r <= '0;
    end else begin
      acc_r <= acc_nxt;
    end
  end

  // The prescaler counts slow ticks and so stops while the slow clock is gated.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pre_r <= '0;
    end else if (slow_tick) begin
      pre_r <= sec_tick ? '0 : pre_r + PRE_W'(1);
    end
  end

  // The seconds counter loses the gated interval.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      sec_r <= `RTCSW_SECONDS_RESET;
    end else begin
      sec_r <= sec_nxt;
    end
  end

  // The wake pin is sampled on every clock, gated or not.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_in_r <= 1'b0;
    end else begin
      wake_in_r <= external_wake_input;
    end
  end

  // The previous wake level feeds the rise detector.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_lvl_q_r <= 1'b0;
    end else begin
      wake_lvl_q_r <= wake_lvl;
    end
  end

  // Filter state and sample count.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      db_state_r <= RTCSW_DB_LOW;
      db_cnt_r <= '0;
    end else begin
      db_state_r <= db_state_nxt;
      db_cnt_r <= db_cnt_nxt;
    end
  end

  // Control word; bits other than the enable are stored as written.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pmctl_r <= `RTCSW_PMCTL_RESET;
    end else if (pm_wr) begin
      pmctl_r <= sel_merge(pmctl_r, wb_dat_i, wb_sel_i);
    end
  end

  // Interrupt mask, written lane by lane.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_r <= `RTCSW_MASK_RESET;
    end else if (mask_wr) begin
      mask_r <= (wb_dat_i[2:0] & wmask[2:0]) | (mask_r & ~wmask[2:0]);
    end
  end

  // Sticky status bits.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      status_r <= 3'h0;
    end else begin
      status_r <= status_nxt;
    end
  end

  // Ack is a one-cycle pulse for each taken request.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  // Read data is captured as the request is taken and stands until the next read.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      dat_r <= 32'h0000_0000;
    end else if (rd) begin
      dat_r <= rd_mux;
    end
  end

  // Outputs come from flip-flops; the interrupt is formed from registers only.
  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign slow_clock_gated = gated_r;
  assign wake_detected = status_r[`RTCSW_EVT_WAKE_BIT];
  assign seconds_count = sec_r;
  assign irq = |(status_r & mask_r);

endmodule
`default_nettype wire

/* File: tb/rtcsw_top_monitor.sv */
// Port checker of the slow-clock block.
`default_nettype none
`include "rtcsw_cfg.svh"
module rtcsw_top_monitor (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic [`RTCSW_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] seconds_count,
  input wire logic core_supply_ok,
  input wire logic power_on_reset_input_n,
  input wire logic external_wake_input,
  input wire logic slow_clock_gated,
  input wire logic wake_detected
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  logic db_en_r;
  wire logic pm_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && wb_adr_i == `RTCSW_OFF_PMCTL;
  // Follows the de-bounce enable as software writes it.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) db_en_r <= 1'b0;
    else if (pm_wr) db_en_r <= wb_dat_i[0];
  end
  sequence quiet_gate;
    slow_clock_gated && !wb_cyc_i;
  endsequence
  chk_gate_on: assert property (!(core_supply_ok && power_on_reset_input_n) |=> slow_clock_gated)
    else $error("gate not entered");
  chk_gate_off: assert property (core_supply_ok && power_on_reset_input_n |=> !slow_clock_gated)
    else $error("gate not left");
  chk_time_hold: assert property (quiet_gate [*3] |-> $stable(seconds_count))
    else $error("seconds moved while gated");
  chk_bypass_wake: assert property (!db_en_r && !wake_detected && $rose(external_wake_input) |-> ##2 wake_detected)
    else $error("bypassed wake missed");
  chk_wake_lost: assert property ((db_en_r && slow_clock_gated && !wake_detected) [*3] |=> !wake_detected)
    else $error("filtered wake seen while gated");
  chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
endmodule
bind rtcsw_top rtcsw_top_monitor rtcsw_top_monitor_inst (.mclk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_ack_o,
  .wb_adr_i, .wb_sel_i, .wb_dat_i, .seconds_count, .core_supply_ok, .power_on_reset_input_n, .external_wake_input,
  .slow_clock_gated, .wake_detected);
`default_nettype wire

/* File: tb/rtcsw_wake_src.sv */
// Model of the wake source and the supply and reset pins.
`default_nettype none
module rtcsw_wake_src (
  input wire logic mclk,
  input wire logic supply_drop,
  input wire logic reset_hold,
  input wire logic wake_cmd,
  output logic core_supply_ok,
  output logic power_on_reset_input_n,
  output logic external_wake_input
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {core_supply_ok, power_on_reset_input_n, external_wake_input} = 3'h6;
  always @(posedge mclk) begin
    core_supply_ok <= !supply_drop;
    power_on_reset_input_n <= !reset_hold;
    external_wake_input <= wake_cmd;
  end
endmodule
`default_nettype wire

/* File: tb/tb_rtcsw_top.sv */
// Self-checking bench of the slow-clock block.
`default_nettype none
`include "rtcsw_cfg.svh"
module tb_rtcsw_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, sys_rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, supply_drop, reset_hold, wake_cmd, irq;
  logic core_supply_ok, power_on_reset_input_n, external_wake_input, slow_clock_gated, wake_detected;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, seconds_count, q, s0;
  int miscompares, cmp_count;
  rtcsw_top #(.SLOW_HZ(`RTCSW_MCLK_HZ / 8), .SEC_DIV(4)) rtcsw_top_inst (.mclk, .sys_rst, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .core_supply_ok, .power_on_reset_input_n,
    .external_wake_input, .slow_clock_gated, .wake_detected, .seconds_count, .irq);
  rtcsw_wake_src rtcsw_wake_src_inst (.mclk, .supply_drop, .reset_hold, .wake_cmd, .core_supply_ok,
    .power_on_reset_input_n, .external_wake_input);
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    if (wb_ack_o !== 1'b1) begin
      miscompares++;
      complete_run();
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, supply_drop, reset_hold, wake_cmd} = 6'h00;
    {wb_adr_i, wb_sel_i, wb_dat_i} = {8'h00, 4'hF, 32'h0};
    sys_rst = 1'b1;
    tick(12);
    sys_rst <= 1'b0;
    wb(0, `RTCSW_OFF_PMCTL, 0);
    chk(q, `RTCSW_PMCTL_RESET, "pmctl reset");
    wb(0, 8'h40, 0);
    chk(q, 32'h0, "unmapped read");
    $display("test reset done");
    for (int i = 0; i < 2; i++) begin
      {supply_drop, reset_hold} <= {i == 0, i == 1};
      tick(5);
      wb(0, `RTCSW_OFF_SECONDS, 0);
      s0 = q;
      tick(100);
      wb(0, `RTCSW_OFF_STATE, 0);
      chk(32'(q[0]), 32'h1, "gated state");
      chk(32'(slow_clock_gated), 32'h1, "gated pin");
      wb(0, `RTCSW_OFF_SECONDS, 0);
      chk(q, s0, "held seconds");
      chk(seconds_count, s0, "seconds pin");
      {supply_drop, reset_hold} <= 2'h0;
      tick(100);
      wb(0, `RTCSW_OFF_SECONDS, 0);
      chk(32'(q > s0), 32'h1, "running seconds");
    end
    wb(0, `RTCSW_OFF_STATUS, 0);
    chk(32'(q[2:1]), 32'h3, "tick and gate events");
    $display("test gating done");
    wb(1, `RTCSW_OFF_MASK, 1);
    supply_drop <= 1'b1;
    tick(5);
    wake_cmd <= 1'b1;
    tick(1);
    wake_cmd <= 1'b0;
    tick(5);
    chk(32'(wake_detected), 32'h1, "bypass wake");
    chk(32'(irq), 32'h1, "irq raised");
    wb(1, `RTCSW_OFF_MASK, 0);
    chk(32'(irq), 32'h0, "irq masked");
    wb(1, `RTCSW_OFF_MASK, 1);
    wb(1, `RTCSW_OFF_STATUS, 1);
    chk(32'(wake_detected), 32'h0, "wake cleared");
    chk(32'(irq), 32'h0, "irq cleared");
    $display("test bypass done");
    wb(1, `RTCSW_OFF_PMCTL, 1);
    wb(0, `RTCSW_OFF_PMCTL, 0);
    chk(q, 32'h1, "pmctl readback");
    wake_cmd <= 1'b1;
    tick(40);
    wake_cmd <= 1'b0;
    tick(5);
    supply_drop <= 1'b0;
    tick(60);
    chk(32'(wake_detected), 32'h0, "lost wake");
    wake_cmd <= 1'b1;
    tick(60);
    chk(32'(wake_detected), 32'h1, "filtered wake");
    $display("test debounce done");
    complete_run();
  end
endmodule
`default_nettype wire
